// ===== hdl/acsc_top.v
// acsc_top.v: start gate, calibration sequencing and result scaling
// assumes raw results arrive from the modulator with a one-cycle strobe
//
// Implementation choices: strobed register access and the register addresses.
`default_nettype none
`include "acsc_defs.vh"
module acsc_top
#(
	parameter NCH = 8,
	parameter CW  = 3
)
(
	// clock and reset
	input  wire        mclk,
	input  wire        arst_n,
	// register port
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	// modulator side
	input  wire [23:0] raw_data,
	input  wire        raw_valid,
	output reg         mod_run,
	output reg         mod_short,
	output reg         mod_neg_common,
	output reg         mod_fs_ref,
	output reg  [1:0]  mod_range,
	output reg  [CW-1:0] mod_chan,
	// pins
	input  wire        gate_pin_in,
	output wire        gate_pin_out,
	output wire        gate_pin_oe,
	output wire        general_output_pin,
	output wire        common_input_terminal_sel,
	output reg         ready_n
);
	// ****************************************
	// state encoding
	// ****************************************
	localparam S_IDLE = 4'b0001;
	localparam S_WAIT = 4'b0010;
	localparam S_RUN  = 4'b0100;
	localparam S_CAL  = 4'b1000;

	wire rst_n;
	acsc_sync_reset acsc_sync_reset_inst
	(
		.mclk   (mclk),
		.arst_n (arst_n),
		.rst_n  (rst_n)
	);

	reg  [2:0]     mode;
	reg  [4:0]     port;
	reg  [2:0]     setup [0:NCH-1];
	reg  [15:0]    ctime [0:NCH-1];
	reg  [22:0]    ch_zs [0:NCH-1];
	reg  [23:0]    ch_fs [0:NCH-1];
	reg  [NCH-1:0] rdy;
	reg  [23:0]    data;
	reg  [23:0]    adc_zs;
	reg  [23:0]    adc_fs;
	reg  [23:0]    last_raw;
	reg  [3:0]     state;
	reg  [15:0]    cnt;
	reg            gate_q;
	reg            gate_low;
	reg            cal_done;
	reg  [CW-1:0]  sel;
	reg  [31:0]    next_rdata;
	wire [23:0]    scaled;
	wire [CW-1:0]  wch;
	wire           idle;
	wire           is_cal;
	wire           gated;
	wire           r_two;

	function is_cal_mode;
		input [2:0] m;
		begin
			is_cal_mode = m[2];
		end
	endfunction

	assign wch = wdata[`ACSC_F_WCH+CW-1:`ACSC_F_WCH];
	assign idle = (state == S_IDLE);
	assign is_cal = is_cal_mode(mode);
	assign gated = port[`ACSC_P_GATE] & ~gate_pin_in;
	assign r_two = (setup[sel][1:0] == `ACSC_RNG_0625);

	acsc_scale acsc_scale_inst
	(
		.raw     (raw_data),
		.adc_zs  (adc_zs),
		.adc_fs  (adc_fs),
		.ch_zs   (ch_zs[sel]),
		.ch_fs   (ch_fs[sel]),
		.r_two   (r_two),
		.bipolar (setup[sel][`ACSC_S_BIP]),
		.scaled  (scaled)
	);

	// ****************************************
	// pins
	// ****************************************
	assign general_output_pin = port[`ACSC_P_OUT0];
	assign common_input_terminal_sel = port[`ACSC_P_COM0];
	// pin pulled low after calibration while used as gate
	assign gate_pin_out = gate_low ? 1'b0 : port[`ACSC_P_OUT1];
	assign gate_pin_oe = gate_low | port[`ACSC_P_DIR1];

	// ****************************************
	// registers and sequencer
	// ****************************************
	integer i;
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode <= `ACSC_M_IDLE;
			port <= 5'h00;
			for (i = 0; i < NCH; i = i + 1)
			begin
				setup[i] <= 3'h0;
				ctime[i] <= `ACSC_K_CTIME_RST;
				ch_zs[i] <= 23'h000000;
				ch_fs[i] <= `ACSC_K_FS_RST;
			end
			rdy <= {NCH{1'b0}};
			data <= 24'h000000;
			adc_zs <= 24'h000000;
			adc_fs <= `ACSC_K_FS_RST;
			last_raw <= 24'h000000;
			state <= S_IDLE;
			cnt <= 16'h0000;
			// pin idles high: no false rising edge after reset
			gate_q <= 1'b1;
			gate_low <= 1'b0;
			cal_done <= 1'b0;
			sel <= {CW{1'b0}};
			ready_n <= 1'b1;
		end
		else
		begin
			gate_q <= gate_pin_in;
			cal_done <= 1'b0;
			// release the pin on a new start or when gating is switched off
			if ((gate_pin_in & ~gate_q) || (wr && addr == `ACSC_A_MODE) ||
				(wr && addr == `ACSC_A_PORT && !wdata[`ACSC_P_GATE]))
				gate_low <= 1'b0;
			if (rd && addr == `ACSC_A_STATUS && !(state == S_RUN && raw_valid))
				rdy <= {NCH{1'b0}};
			if (wr)
			begin
				case (addr)
					`ACSC_A_MODE:
					begin
						mode <= wdata[2:0];
						sel <= wdata[`ACSC_F_MCH+CW-1:`ACSC_F_MCH];
					end
					`ACSC_A_PORT: port <= wdata[4:0];
					`ACSC_A_SETUP: if (idle) setup[wch] <= wdata[2:0];
					`ACSC_A_CTIME: if (idle) ctime[wch] <= wdata[15:0];
					`ACSC_A_ADCZS: if (idle) adc_zs <= wdata[23:0];
					`ACSC_A_ADCFS: if (idle) adc_fs <= wdata[23:0];
					`ACSC_A_CHZS: if (idle) ch_zs[sel] <= wdata[22:0];
					`ACSC_A_CHFS: if (idle) ch_fs[sel] <= wdata[23:0];
					default: ;
				endcase
			end
			case (state)
				S_IDLE:
				begin
					if (mode != `ACSC_M_IDLE && !(wr && addr == `ACSC_A_MODE))
					begin
						state <= port[`ACSC_P_GATE] ? S_WAIT : (is_cal ? S_CAL : S_RUN);
						cnt <= ctime[sel];
						ready_n <= 1'b1;
					end
				end
				S_WAIT:
				begin
					if (gate_pin_in & ~gate_q)
						state <= is_cal ? S_CAL : S_RUN;
					if (mode == `ACSC_M_IDLE)
						state <= S_IDLE;
				end
				S_RUN:
				begin
					if (!gated && raw_valid)
					begin
						last_raw <= raw_data;
						data <= scaled;
						rdy[sel] <= 1'b1;
						ready_n <= 1'b0;
						if (mode == `ACSC_M_SINGLE)
						begin
							mode <= `ACSC_M_IDLE;
							state <= S_IDLE;
						end
					end
					else if (raw_valid)
						ready_n <= 1'b1;
					if (mode == `ACSC_M_IDLE)
						state <= S_IDLE;
				end
				S_CAL:
				begin
					if (!gated)
					begin
						if (raw_valid)
							last_raw <= raw_data;
						if (cnt <= 16'h0001)
						begin
							case (mode)
								`ACSC_M_ADCZS: adc_zs <= last_raw;
								`ACSC_M_ADCFS: adc_fs <= last_raw;
								`ACSC_M_CHZS: ch_zs[sel] <= last_raw[22:0];
								`ACSC_M_CHFS: ch_fs[sel] <= last_raw;
								default: ;
							endcase
							rdy <= {NCH{1'b1}};
							gate_low <= port[`ACSC_P_GATE];
							mode <= `ACSC_M_IDLE;
							state <= S_IDLE;
							cal_done <= 1'b1;
						end
						else
							cnt <= cnt - 16'h0001;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// modulator steering
	// ****************************************
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mod_run <= 1'b0;
			mod_short <= 1'b0;
			mod_neg_common <= 1'b0;
			mod_fs_ref <= 1'b0;
			mod_range <= 2'h0;
			mod_chan <= {CW{1'b0}};
		end
		else
		begin
			mod_run <= (state == S_RUN || state == S_CAL) && !gated;
			mod_short <= (state == S_CAL) && mode == `ACSC_M_ADCZS;
			mod_neg_common <= (state == S_CAL) && mode == `ACSC_M_ADCZS;
			mod_fs_ref <= (state == S_CAL) && mode == `ACSC_M_ADCFS;
			mod_range <= ((state == S_CAL) && mode == `ACSC_M_ADCFS) ? `ACSC_RNG_2500 : setup[sel][1:0];
			mod_chan <= sel;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always @*
	begin
		next_rdata = 32'h00000000;
		case (addr)
			`ACSC_A_MODE: next_rdata = {25'h0, sel, 1'b0, mode};
			`ACSC_A_PORT: next_rdata = {27'h0, port[4:2], gate_pin_in, port[0]};
			`ACSC_A_SETUP: next_rdata = {29'h0, setup[sel]};
			`ACSC_A_CTIME: next_rdata = {16'h0, ctime[sel]};
			`ACSC_A_STATUS: next_rdata = {24'h0, state, cal_done, ~ready_n, 2'h0} |
				({{(32-NCH){1'b0}}, rdy} << `ACSC_F_RDY);
			`ACSC_A_DATA: next_rdata = {8'h00, data};
			`ACSC_A_ADCZS: next_rdata = {8'h00, adc_zs};
			`ACSC_A_ADCFS: next_rdata = {8'h00, adc_fs};
			`ACSC_A_CHZS: next_rdata = {9'h000, ch_zs[sel]};
			`ACSC_A_CHFS: next_rdata = {8'h00, ch_fs[sel]};
			`ACSC_A_RAW: next_rdata = {8'h00, last_raw};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 32'h00000000;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 32'h00000000;
	end
endmodule
`default_nettype wire

// ===== hdl/acsc_defs.vh
// acsc_defs.vh: constants of the calibration and start-gate control block
// assumes inclusion by bare name from the design files of this block
`ifndef ACSC_DEFS_VH
`define ACSC_DEFS_VH

// register offsets (index, byte address is four times)
`define ACSC_A_MODE      4'h0
`define ACSC_A_PORT      4'h1
`define ACSC_A_SETUP     4'h2
`define ACSC_A_CTIME     4'h3
`define ACSC_A_STATUS    4'h4
`define ACSC_A_DATA      4'h5
`define ACSC_A_ADCZS     4'h6
`define ACSC_A_ADCFS     4'h7
`define ACSC_A_CHZS      4'h8
`define ACSC_A_CHFS      4'h9
`define ACSC_A_RAW       4'hA

// mode codes
`define ACSC_M_IDLE      3'h0
`define ACSC_M_CONT      3'h1
`define ACSC_M_SINGLE    3'h2
`define ACSC_M_ADCZS     3'h4
`define ACSC_M_ADCFS     3'h5
`define ACSC_M_CHZS      3'h6
`define ACSC_M_CHFS      3'h7

// port register fields
`define ACSC_P_OUT0      0
`define ACSC_P_OUT1      1
`define ACSC_P_DIR1      2
`define ACSC_P_COM0      3
`define ACSC_P_GATE      4

// channel setup fields: range code bits 1:0, bipolar bit 2
`define ACSC_RNG_0625    2'h0
`define ACSC_RNG_1250    2'h1
`define ACSC_RNG_2500    2'h2
`define ACSC_S_BIP       2

// field positions: channel in setup and mode writes, ready flags in status
`define ACSC_F_WCH       24
`define ACSC_F_MCH       4
`define ACSC_F_RDY       16

// scaling constants and reset values
`define ACSC_K_UNI_DIV   21
`define ACSC_K_BIP_DIV   22
`define ACSC_K_BIP_OFS   24'h800000
`define ACSC_K_FULL      24'hFFFFFF
`define ACSC_K_FS_RST    24'h200000
`define ACSC_K_CTIME_RST 16'h0100

`endif

// ===== hdl/acsc_sync_reset.v
// acsc_sync_reset.v: reset release synchroniser
// assumes arst_n asynchronous, released anywhere relative to mclk
`default_nettype none
module acsc_sync_reset
(
	// clock and raw reset
	input  wire mclk,
	input  wire arst_n,
	// released copy
	output wire rst_n
);
	reg s1;
	reg s2;
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
		end
		else
		begin
			s1 <= 1'b1;
			s2 <= s1;
		end
	end
	assign rst_n = s2;
endmodule
`default_nettype wire

// ===== hdl/acsc_scale.v
// acsc_scale.v: two-stage calibration scaling of a raw result, combinational
// assumes coefficients stable while result is consumed
`default_nettype none
`include "acsc_defs.vh"
module acsc_scale
(
	// operands
	input  wire [23:0] raw,
	input  wire [23:0] adc_zs,
	input  wire [23:0] adc_fs,
	input  wire [22:0] ch_zs,
	input  wire [23:0] ch_fs,
	input  wire        r_two,
	input  wire        bipolar,
	// scaled result, clamped to 24 bits
	output wire [23:0] scaled
);
	wire signed [26:0] s_raw;
	wire signed [26:0] s_azs;
	wire signed [26:0] s_czs;
	wire signed [52:0] st1m;
	wire signed [52:0] st1;
	wire signed [52:0] st2m;
	wire signed [79:0] st2p;
	wire signed [79:0] st2;
	assign s_raw = {3'h0, raw};
	assign s_azs = r_two ? {2'h0, adc_zs, 1'b0} : {3'h0, adc_zs};
	// sign bit then 22-bit magnitude
	assign s_czs = ch_zs[22] ? -({5'h00, ch_zs[21:0]} << r_two) : ({5'h00, ch_zs[21:0]} << r_two);
	assign st1m = (s_raw - s_azs) * $signed({3'h0, adc_fs});
	assign st1 = bipolar ? ((st1m >>> `ACSC_K_BIP_DIV) + $signed({29'h0, `ACSC_K_BIP_OFS}))
		: (st1m >>> `ACSC_K_UNI_DIV);
	assign st2m = st1 - {{26{s_czs[26]}}, s_czs};
	assign st2p = st2m * $signed({3'h0, ch_fs});
	assign st2 = st2p >>> `ACSC_K_UNI_DIV;
	assign scaled = st2[79] ? 24'h000000 : (|st2[78:24] ? `ACSC_K_FULL : st2[23:0]);
endmodule
`default_nettype wire

// ===== tb/acsc_sva.sv
// acsc_sva.sv: port assertions for acsc_top
// assumes bind onto acsc_top, arst_n active low
`default_nettype none
module acsc_sva
(
	// clock, reset, register port
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic [3:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	// modulator and pins
	input wire logic        raw_valid,
	input wire logic        mod_run,
	input wire logic        mod_short,
	input wire logic        mod_neg_common,
	input wire logic        mod_fs_ref,
	input wire logic [1:0]  mod_range,
	input wire logic        gate_pin_in,
	input wire logic        general_output_pin,
	input wire logic        common_input_terminal_sel,
	input wire logic        ready_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gate_en;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// shadow of the gate enable bit
	always @(posedge mclk or negedge arst_n)
		if (!arst_n)
			gate_en <= 1'b0;
		else if (wr && addr == 4'h1)
			gate_en <= wdata[4];
	short_common_a: assert property (mod_short |-> mod_neg_common) else $error("short without common");
	fs_range_a: assert property (mod_fs_ref |-> mod_range == 2'h2 && !mod_short) else $error("fs range");
	com_sel_a: assert property (wr && addr == 4'h1 |=> common_input_terminal_sel == $past(wdata[3]))
		else $error("common select");
	out_pin_a: assert property (wr && addr == 4'h1 |=> general_output_pin == $past(wdata[0]))
		else $error("output pin");
	gate_hold_a: assert property ($past(gate_en) && !$past(gate_pin_in) && !$past(gate_pin_in, 2) |-> !mod_run)
		else $error("run while gated");
	gate_start_a: assert property ($past(gate_en) && $rose(mod_run) |-> $past(gate_pin_in))
		else $error("start without pin high");
	ready_fall_a: assert property ($fell(ready_n) |-> $past(raw_valid && mod_run)) else $error("ready early");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("stray read data");
endmodule
bind acsc_top acsc_sva acsc_sva_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .raw_valid(raw_valid), .mod_run(mod_run), .mod_short(mod_short), .mod_neg_common(mod_neg_common),
	.mod_fs_ref(mod_fs_ref), .mod_range(mod_range), .gate_pin_in(gate_pin_in), .general_output_pin(general_output_pin),
	.common_input_terminal_sel(common_input_terminal_sel), .ready_n(ready_n));
`default_nettype wire

// ===== tb/acsc_mod_model.sv
// acsc_mod_model.sv: modulator stand-in giving raw results
// assumes mod_run from acsc_top, level set by the bench
`default_nettype none
module acsc_mod_model
(
	// control
	input wire logic        mclk,
	input wire logic        mod_run,
	input wire logic [23:0] level,
	// result stream
	output logic     [23:0] raw_data,
	output logic            raw_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	initial
	begin
		cnt = 4'h0;
		raw_valid = 1'b0;
		raw_data = 24'h0;
	end
	// one result per 16 cycles, data toggles outside the strobe
	always @(posedge mclk)
	begin
		cnt <= mod_run ? cnt + 4'h1 : 4'h0;
		raw_valid <= mod_run && cnt == 4'hF;
		raw_data <= (mod_run && cnt == 4'hF) ? level : ~raw_data;
	end
endmodule
`default_nettype wire

// ===== tb/tb_adc_calibration_sync_control.sv
// tb_adc_calibration_sync_control.sv: self-checking bench of acsc_top
// assumes acsc_mod_model as modulator, bench as host
`default_nettype none
module tb_adc_calibration_sync_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, wr, rd, raw_valid, gate_lvl, pin, gp, cs, ready_n;
	logic        mod_run, mod_short, mod_neg_common, mod_fs_ref, gate_pin_out, gate_pin_oe;
	logic [1:0]  mod_range;
	logic [2:0]  mod_chan;
	logic [3:0]  addr, fl;
	logic [23:0] raw_data, level;
	logic [31:0] wdata, rdata, d;
	int          failures, checked, n;
	assign pin = gate_pin_oe ? gate_pin_out : gate_lvl;
	acsc_top acsc_top_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .raw_data(raw_data), .raw_valid(raw_valid), .mod_run(mod_run), .mod_short(mod_short),
		.mod_neg_common(mod_neg_common), .mod_fs_ref(mod_fs_ref), .mod_range(mod_range), .mod_chan(mod_chan),
		.gate_pin_in(pin), .gate_pin_out(gate_pin_out), .gate_pin_oe(gate_pin_oe), .general_output_pin(gp),
		.common_input_terminal_sel(cs), .ready_n(ready_n));
	acsc_mod_model acsc_mod_model_inst (.mclk(mclk), .mod_run(mod_run), .level(level), .raw_data(raw_data),
		.raw_valid(raw_valid));
	// ****************
	// bus and helpers
	// ****************
	task chk(input string s, input [31:0] seen, input [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task w(input [3:0] a, input [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task r(input [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task cal(input [2:0] m);
		w(4'h0, {29'h0, m});
		n = 0;
		for (int i = 0; i < 2000 && !(n > 0 && !mod_run); i++)
		begin
			@(posedge mclk) #1;
			if (mod_run)
				n++;
			if (n == 10)
				fl = {mod_short, mod_neg_common, mod_fs_ref, mod_range == 2'h2};
		end
		chk("cal length", n, 256);
		r(4'h4);
		chk("cal flags", d[23:16], 8'hFF);
		chk("cal idle", d[7:4], 4'h1);
	endtask
	task done(input [23:0] e);
		for (int i = 0; i < 300 && raw_valid !== 1'b1; i++)
			@(posedge mclk) #1;
		@(posedge mclk);
		#1 chk("ready", ready_n, 0);
		r(4'h5);
		chk("data", d, e);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_regs;
		r(4'h3);
		chk("ctime", d, 32'h100);
		r(4'h9);
		chk("ch fs", d, 32'h200000);
		r(4'hF);
		chk("unmapped", d, 0);
		w(4'h1, 32'h9);
		#1 chk("out pin", gp, 1);
		chk("com sel", cs, 1);
		w(4'h1, 32'h0);
		w(4'h0, 32'h20);
		@(posedge mclk) #1;
		chk("channel", mod_chan, 2);
		w(4'h0, 32'h0);
		$display("regs test done");
	endtask
	task t_cal;
		level = 24'h0;
		cal(3'h4);
		chk("zs flags", fl[3:2], 2'h3);
		r(4'h6);
		chk("adc zs", d, 0);
		level = 24'h200000;
		w(4'h2, 32'h0);
		cal(3'h5);
		chk("fs flags", fl[1:0], 2'h3);
		w(4'h2, 32'h1);
		cal(3'h6);
		r(4'h8);
		chk("ch zs cal", d, 32'h200000);
		cal(3'h7);
		r(4'h0);
		chk("mode", d[2:0], 0);
		$display("cal test done");
	endtask
	task t_conv;
		w(4'h8, 32'h10);
		w(4'h9, 32'h100000);
		w(4'h2, 32'h0);
		level = 24'h1000;
		w(4'h0, 32'h2);
		done(24'h7F0);
		w(4'h2, 32'h6);
		w(4'h0, 32'h1);
		done(24'h4003F8);
		done(24'h4003F8);
		w(4'h8, 32'h55);
		w(4'h0, 32'h0);
		r(4'h8);
		chk("busy write", d, 32'h10);
		$display("conv test done");
	endtask
	task t_gate;
		gate_lvl <= 1'b0;
		w(4'h1, 32'h10);
		w(4'h0, 32'h2);
		repeat (40) @(posedge mclk);
		#1 chk("gated run", mod_run, 0);
		chk("ready idle", ready_n, 1);
		gate_lvl <= 1'b1;
		done(24'h4003F8);
		level = 24'h20;
		gate_lvl <= 1'b0;
		fork
			cal(3'h4);
			begin
				repeat (30) @(posedge mclk);
				gate_lvl <= 1'b1;
			end
		join
		chk("pin low", {gate_pin_oe, gate_pin_out}, 2'h2);
		w(4'h1, 32'h0);
		#1 chk("pin free", gate_pin_oe, 0);
		r(4'h6);
		chk("gated zs", d, 32'h20);
		$display("gate test done");
	endtask
	task t_reset;
		w(4'h3, 32'h40);
		r(4'h3);
		chk("ctime wr", d, 32'h40);
		@(posedge mclk);
		arst_n <= 1'b0;
		@(posedge mclk) #1;
		chk("reset ready", ready_n, 1);
		chk("reset run", mod_run, 0);
		chk("reset pin", gate_pin_oe, 0);
		@(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		r(4'h3);
		chk("reset ctime", d, 32'h100);
		$display("reset test done");
	endtask
	task finish_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		{arst_n, wr, rd, addr, wdata} = '0;
		{failures, checked, level} = '0;
		gate_lvl = 1'b1;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_regs;
		t_cal;
		t_conv;
		t_gate;
		t_reset;
		finish_test;
	end
	// watchdog
	initial
	begin
		#200us;
		failures++;
		finish_test;
	end
endmodule
`default_nettype wire
